// file: pkg/gate_cfg_consts.svh
/*
 * Constants of the gate driver and regulator configuration word: its
 * register index, field positions, field widths and reset values.
 * Assumes it is included by bare name, by the modules that use it.
 */
`ifndef GATE_CFG_CONSTS_SVH
`define GATE_CFG_CONSTS_SVH

// Register index of the configuration word on the plain register port.
`define GDC_ADDR_CONFIG_TWO     8'hae

// Field positions, most significant bit first.
`define GDC_POS_PARITY          31
`define GDC_POS_COMP_EN         30
`define GDC_POS_TARGET_HI       29
`define GDC_POS_TARGET_LO       26
`define GDC_POS_SEQ_DIS         24
`define GDC_POS_CUR_LIM         23
`define GDC_POS_VSEL_HI         22
`define GDC_POS_VSEL_LO         21
`define GDC_POS_REG_DIS         20
`define GDC_POS_MINON_HI        19
`define GDC_POS_MINON_LO        17

// Reset values of each field.
`define GDC_RST_PARITY          1'h0
`define GDC_RST_COMP_EN         1'h0
`define GDC_RST_TARGET          4'h0
`define GDC_RST_SEQ_DIS         1'h1
`define GDC_RST_CUR_LIM         1'h0
`define GDC_RST_VSEL            2'h1
`define GDC_RST_REG_DIS         1'h0
`define GDC_RST_MINON           3'h0

// Codes with a special meaning.
`define GDC_TARGET_AUTO         4'h0
`define GDC_TARGET_MAX          4'h9
`define GDC_MINON_AUTO          3'h1

// Read value of an unmapped index.
`define GDC_READ_ZERO           32'h0000_0000

`endif

// file: pkg/gate_cfg_pkg.sv
/*
 * Types of the gate driver configuration block: the field group and the
 * whole registered state of the block.
 * Assumes nothing of its surroundings.
 */
package gate_cfg_pkg;

	// Stored fields of the configuration word.
	typedef struct packed {
		logic       parity;
		logic       comp_en;
		logic [3:0] target_delay;
		logic       regulator_sequencing_disable;
		logic       regulator_current_limit_select;
		logic [1:0] regulator_voltage_select;
		logic       regulator_disable;
		logic [2:0] min_on_time;
	} cfg_fields_t;

	// Everything the block holds in flip-flops.
	typedef struct packed {
		cfg_fields_t cfg;
		logic [31:0] rdata;
	} cfg_state_t;

endpackage

// file: design/gate_driver_config_two.sv
/*
 * Gate driver and buck regulator configuration word, one 32-bit register
 * behind a plain register port, driving field levels to the analog blocks.
 * Assumes a master that holds each strobe for one cycle, never raises both
 * strobes together, and samples read data in the cycle after the read.
 */
`timescale 1ns/1ps
`default_nettype none

`include "gate_cfg_consts.svh"

module gate_driver_config_two #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	output logic                   delay_comp_enable,
	output logic      [3:0]        delay_target,
	output logic                   delay_target_auto,
	output logic                   delay_target_valid,
	output logic                   regulator_sequencing_disable,
	output logic                   regulator_current_limit_select,
	output logic      [1:0]        regulator_voltage_select,
	output logic                   regulator_disable,
	output logic      [2:0]        min_on_time,
	output logic                   min_on_time_auto
);

	gate_cfg_pkg::cfg_state_t state_r;
	gate_cfg_pkg::cfg_state_t state_nxt;
	logic                     hit;
	logic [31:0]              word;

	// Index compare; the index is widened so a narrow port never truncates it.
	assign hit = ({{(32-ADDR_W){1'b0}}, reg_addr} == 32'(`GDC_ADDR_CONFIG_TWO));

	// Read image; reserved positions stay zero because nothing drives them.
	always_comb begin
		word = `GDC_READ_ZERO;
		word[`GDC_POS_PARITY] = state_r.cfg.parity;
		word[`GDC_POS_COMP_EN] = state_r.cfg.comp_en;
		word[`GDC_POS_TARGET_HI:`GDC_POS_TARGET_LO] = state_r.cfg.target_delay;
		word[`GDC_POS_SEQ_DIS] = state_r.cfg.regulator_sequencing_disable;
		word[`GDC_POS_CUR_LIM] = state_r.cfg.regulator_current_limit_select;
		word[`GDC_POS_VSEL_HI:`GDC_POS_VSEL_LO] = state_r.cfg.regulator_voltage_select;
		word[`GDC_POS_REG_DIS] = state_r.cfg.regulator_disable;
		word[`GDC_POS_MINON_HI:`GDC_POS_MINON_LO] = state_r.cfg.min_on_time;
	end

	// Next state: writes update fields, reads capture the image for the next cycle.
	always_comb begin
		state_nxt = state_r;
		if (reg_wr && hit) begin
			state_nxt.cfg.parity = reg_wdata[`GDC_POS_PARITY];
			state_nxt.cfg.comp_en = reg_wdata[`GDC_POS_COMP_EN];
			state_nxt.cfg.target_delay =
				reg_wdata[`GDC_POS_TARGET_HI:`GDC_POS_TARGET_LO];
			// A written one clears; a written zero leaves the bit as it stands.
			if (reg_wdata[`GDC_POS_SEQ_DIS]) begin
				state_nxt.cfg.regulator_sequencing_disable = 1'b0;
			end
			state_nxt.cfg.regulator_current_limit_select =
				reg_wdata[`GDC_POS_CUR_LIM];
			state_nxt.cfg.regulator_voltage_select =
				reg_wdata[`GDC_POS_VSEL_HI:`GDC_POS_VSEL_LO];
			state_nxt.cfg.regulator_disable = reg_wdata[`GDC_POS_REG_DIS];
			state_nxt.cfg.min_on_time =
				reg_wdata[`GDC_POS_MINON_HI:`GDC_POS_MINON_LO];
		end
		// Read data stand for exactly one cycle; an unmapped index reads zero.
		if (reg_rd) begin
			state_nxt.rdata = hit ? word : `GDC_READ_ZERO;
		end else begin
			state_nxt.rdata = `GDC_READ_ZERO;
		end
	end

	// State register with synchronous active-low reset to the documented values.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_r.cfg.parity <= `GDC_RST_PARITY;
			state_r.cfg.comp_en <= `GDC_RST_COMP_EN;
			state_r.cfg.target_delay <= `GDC_RST_TARGET;
			state_r.cfg.regulator_sequencing_disable <= `GDC_RST_SEQ_DIS;
			state_r.cfg.regulator_current_limit_select <= `GDC_RST_CUR_LIM;
			state_r.cfg.regulator_voltage_select <= `GDC_RST_VSEL;
			state_r.cfg.regulator_disable <= `GDC_RST_REG_DIS;
			state_r.cfg.min_on_time <= `GDC_RST_MINON;
			state_r.rdata <= `GDC_READ_ZERO;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Field levels to the analog side, straight from flip-flops.
	assign reg_rdata = state_r.rdata;
	assign delay_comp_enable = state_r.cfg.comp_en;
	assign delay_target = state_r.cfg.target_delay;
	assign regulator_sequencing_disable = state_r.cfg.regulator_sequencing_disable;
	assign regulator_current_limit_select = state_r.cfg.regulator_current_limit_select;
	assign regulator_voltage_select = state_r.cfg.regulator_voltage_select;
	assign regulator_disable = state_r.cfg.regulator_disable;
	assign min_on_time = state_r.cfg.min_on_time;

	// Decoded hints; codes above nine are stored but flagged, since their delay is undefined.
	assign delay_target_auto = (state_r.cfg.target_delay == `GDC_TARGET_AUTO);
	assign delay_target_valid = (state_r.cfg.target_delay <= `GDC_TARGET_MAX);
	assign min_on_time_auto = (state_r.cfg.min_on_time == `GDC_MINON_AUTO);

endmodule

`default_nettype wire

// file: testbench/gate_cfg_asserts.sv
/* Checker of the configuration word's port timing, bound to the block.
   Assumes the register index from the constants header. */
`timescale 1ns/1ps
`default_nettype none
`include "gate_cfg_consts.svh"
module gate_cfg_chk #(
	parameter int ADDR_W = 8
) (
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [31:0]       reg_rdata,
	input wire logic              delay_comp_enable,
	input wire logic [3:0]        delay_target,
	input wire logic              regulator_sequencing_disable,
	input wire logic              regulator_current_limit_select,
	input wire logic [1:0]        regulator_voltage_select,
	input wire logic              regulator_disable,
	input wire logic [2:0]        min_on_time
);
	// Field pins packed in word order, plus one-cycle copies to compare against.
	wire logic [12:0] fld = {delay_comp_enable, delay_target, regulator_sequencing_disable,
		regulator_current_limit_select, regulator_voltage_select, regulator_disable, min_on_time};
	wire logic        hit = reg_addr == `GDC_ADDR_CONFIG_TWO;
	logic      [31:0] wd_r;
	logic      [12:0] fld_r;
	always_ff @(posedge clk_sys) begin
		wd_r <= reg_wdata;
		fld_r <= fld;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	chk_comp_target_write: assert property (
		reg_wr && hit |=> fld[12:8] == wd_r[30:26])
		else $error("enable or target not written");
	chk_seq_clear: assert property (reg_wr && hit && reg_wdata[24] |=> !fld[7])
		else $error("sequencing disable not cleared");
	chk_seq_hold: assert property (
		!(reg_wr && hit && reg_wdata[24]) |=> $stable(fld[7]))
		else $error("sequencing disable moved");
	chk_buck_write: assert property (
		reg_wr && hit |=> fld[6:3] == wd_r[23:20])
		else $error("regulator fields not written");
	chk_minon_write: assert property (reg_wr && hit |=> fld[2:0] == wd_r[19:17])
		else $error("minimum on-time not written");
	chk_fields_hold: assert property (
		!(reg_wr && hit) |=> $stable(fld))
		else $error("field changed without write");
	chk_read_image: assert property (
		reg_rd && hit |=> reg_rdata[30:0] == {fld_r[12:8], 1'b0, fld_r[7:0], 17'h0})
		else $error("read image wrong");
	chk_rdata_idle: assert property (!(reg_rd && hit) |=> reg_rdata == 32'h0)
		else $error("read data not zero");
	// Main scenarios: clearing write, back-to-back write and read, reads two cycles apart.
	cover property (reg_wr && hit && reg_wdata[24]);
	cover property (reg_wr ##1 reg_rd);
	cover property (reg_rd ##2 reg_rd);
endmodule
bind gate_driver_config_two gate_cfg_chk #(.ADDR_W(ADDR_W)) chk_i (.*);
`default_nettype wire

// file: testbench/gate_driver_config_two_tb.sv
/* Bench of the configuration word: drives the register port, judges reads and pins.
   Assumes the design and the constants header. */
`timescale 1ns/1ps
`default_nettype none
module gate_driver_config_two_tb;
	logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic delay_comp_enable, delay_target_auto, delay_target_valid, regulator_disable;
	logic regulator_sequencing_disable, regulator_current_limit_select, min_on_time_auto;
	logic [3:0] delay_target;
	logic [1:0] regulator_voltage_select;
	logic [2:0] min_on_time;
	int failures = 0, compares = 0;
	gate_driver_config_two #(.ADDR_W(8)) dut (.*);
	// Free-running 10 MHz clock.
	always #50 clk_sys = ~clk_sys;
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// With now set the read follows a write with no gap.
	task automatic rd(logic [7:0] a, logic [31:0] e, bit now);
		if (!now) @(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk("read data", e, reg_rdata);
	endtask
	task automatic pins(logic [31:0] w, logic s);
		chk("fields", {w[30:26], s, w[23:17]}, {delay_comp_enable, delay_target,
			regulator_sequencing_disable, regulator_current_limit_select,
			regulator_voltage_select, regulator_disable, min_on_time});
		chk("code flags", {w[29:26] == 4'h0, w[29:26] <= 4'h9, w[19:17] == 3'h1},
			{delay_target_auto, delay_target_valid, min_on_time_auto});
	endtask
	task automatic t_seq;
		wr(8'hae, 32'h0);
		rd(8'hae, 32'h0100_0000, 1);
		wr(8'hae, 32'h0100_0000);
		rd(8'hae, 32'h0, 1);
		wr(8'hae, 32'h0);
		rd(8'hae, 32'h0, 1);
	endtask
	task automatic t_all;
		wr(8'hae, 32'hffff_ffff);
		rd(8'hae, 32'hfcfe_0000, 1);
		pins(32'hffff_ffff, 1'b0);
		wr(8'ha0, 32'h0);
		rd(8'ha0, 32'h0, 0);
		rd(8'hae, 32'hfcfe_0000, 0);
	endtask
	// Every code of target, voltage and on-time, with the pins after each.
	task automatic t_codes;
		logic [31:0] w;
		for (int i = 0; i < 16; i++) begin
			w = (32'(i) << 26) | (32'(i & 3) << 21) | (32'(i & 7) << 17);
			wr(8'hae, w);
			rd(8'hae, w, 1);
			pins(w, 1'b0);
		end
	endtask
	task automatic finish_test;
		if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence; a second reset comes after the code sweep, with target, voltage and on-time nonzero.
	initial begin
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(8'hae, 32'h0120_0000, 0);
		pins(32'h0020_0000, 1'b1);
		@(posedge clk_sys);
		#1 chk("idle read data", 32'h0, reg_rdata);
		t_seq();
		t_all();
		t_codes();
		@(posedge clk_sys);
		resetn <= 1'b0;
		@(posedge clk_sys);
		resetn <= 1'b1;
		rd(8'hae, 32'h0120_0000, 0);
		pins(32'h0020_0000, 1'b1);
		finish_test();
	end
	// Cuts a hang short.
	initial begin
		#2000000;
		failures++;
		finish_test();
	end
endmodule
`default_nettype wire
